// File: dv/rail_bc_voltage_step_comp_regs_tb.sv
// self-checking bench for the rail B/C step-compensation register bank
// assumes rtl/ compiled first; bench drives the serial bus pins itself
`timescale 1ns/1ps
`default_nettype none

module rail_bc_voltage_step_comp_regs_tb;

  logic            clk;
  logic            reset_n;
  logic            ce;
  logic            sclM;
  logic            sdaM;
  wire logic       sdaW;
  logic            sdaOut;
  logic            sdaOe;
  logic [1:0]      rampDown;
  logic            lightExit;
  logic [1:0][3:0] liftSetting;
  logic [1:0][2:0] senseGain;
  logic [1:0][2:0] rippleCode;
  logic [7:0]      railBCtrl;
  logic [7:0]      railCCtrl;
  logic [1:0]      fixedLiftOn;
  logic [1:0][6:0] pullCurrent;
  logic [1:0][3:0] senseGainEff;
  logic [1:0][3:0] rippleFactor;
  logic [1:0]      targetRaise;
  logic [1:0]      filterClear;
  logic [7:0]      rd;
  logic [7:0]      b;
  logic [7:0]      c;
  int              error_cnt;
  int              num_checks;
  int              seed;
  int              regVal [2];

  // open-drain wire with pull-up
  assign sdaW = sdaM & ~(sdaOe & ~sdaOut);

  rail_step_comp_regs dut_u (
    .clk(clk), .reset_n(reset_n), .ce(ce), .sclIn(sclM), .sdaIn(sdaW),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .rampDown(rampDown),
    .lightExit(lightExit), .liftSetting(liftSetting),
    .senseGain(senseGain), .rippleCode(rippleCode),
    .railBCtrl(railBCtrl), .railCCtrl(railCCtrl),
    .fixedLiftOn(fixedLiftOn), .pullCurrent(pullCurrent),
    .senseGainEff(senseGainEff), .rippleFactor(rippleFactor),
    .targetRaise(targetRaise), .filterClear(filterClear)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // half bus period, six clocks keeps well above the 4-clock minimum
  task automatic hp();
    repeat (6) @(posedge clk);
  endtask

  task automatic bitCyc(input logic bv, output logic s);
    sdaM <= bv;
    hp();
    sclM <= 1'b1;
    repeat (3) @(posedge clk);
    #1 s = sdaW;
    repeat (3) @(posedge clk);
    sclM <= 1'b0;
    hp();
  endtask

  task automatic startC();
    sdaM <= 1'b1;
    hp();
    sclM <= 1'b1;
    hp();
    sdaM <= 1'b0;
    hp();
    sclM <= 1'b0;
    hp();
  endtask

  task automatic stopC();
    sdaM <= 1'b0;
    hp();
    sclM <= 1'b1;
    hp();
    sdaM <= 1'b1;
    hp();
  endtask

  task automatic sendByte(input logic [7:0] v, input logic expNack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitCyc(v[i], s);
    bitCyc(1'b1, s);
    chk({31'h0, s}, {31'h0, expNack});
  endtask

  task automatic regWr(input logic [7:0] a, input logic [7:0] d0,
                       input logic [7:0] d1, input int n);
    startC();
    sendByte({rail_comp_pkg::DEVICE_BUS_ADDR, 1'b0}, 1'b0);
    sendByte(a, 1'b0);
    for (int k = 0; k < n; k++)
    begin
      sendByte(k == 0 ? d0 : d1, 1'b0);
      // pointer steps one per data byte
      if (a + k == 1 || a + k == 2)
        regVal[a + k - 1] = (k == 0) ? d0 : d1;
    end
    stopC();
  endtask

  task automatic regRd(input logic [7:0] a, output logic [7:0] d);
    logic s;
    startC();
    sendByte({rail_comp_pkg::DEVICE_BUS_ADDR, 1'b0}, 1'b0);
    sendByte(a, 1'b0);
    startC();
    sendByte({rail_comp_pkg::DEVICE_BUS_ADDR, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--)
      bitCyc(1'b1, d[i]);
    bitCyc(1'b1, s);
    stopC();
  endtask

  // random regulator inputs each cycle, outputs checked one cycle later
  task automatic decRun(input int n);
    logic [1:0]      pr;
    logic            pe;
    logic [1:0][3:0] pl;
    logic [1:0][2:0] pg;
    logic [1:0][2:0] pp;
    logic [1:0]      nr;
    logic            ne;
    logic [1:0][3:0] nl;
    logic [1:0][2:0] ng;
    logic [1:0][2:0] np;
    int              v;
    for (int k = 0; k <= n; k++)
    begin
      @(posedge clk);
      nr = $random(seed);
      ne = $random(seed);
      nl = $random(seed);
      ng = $random(seed);
      np = $random(seed);
      ng[1][2] = 1'b0;
      rampDown <= nr;
      lightExit <= ne;
      liftSetting <= nl;
      senseGain <= ng;
      rippleCode <= np;
      #1;
      if (k > 0)
      begin
        for (int r = 0; r < 2; r++)
        begin
          v = regVal[r];
          chk(fixedLiftOn[r], pr[r] & ~v[7]);
          chk(pullCurrent[r], pr[r] ? pl[r] * v[6:4] : 0);
          chk(senseGainEff[r], v[1] ? pg[r] * 2 : pg[r]);
          chk(rippleFactor[r], v[0] ? pp[r] * 2 : pp[r]);
        end
        v = regVal[0];
        chk(targetRaise, {1'b0, pe & v[3]});
        chk(filterClear, {1'b0, pe & v[2]});
      end
      {pr, pe, pl, pg, pp} = {nr, ne, nl, ng, np};
    end
    @(posedge clk);
    lightExit <= 1'b0;
    rampDown <= 2'b00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h49a2fde3;
    // reset low, clock enable high, bus idle, regulator quiet
    {reset_n, ce, sclM, sdaM, rampDown, lightExit} = 7'h38;
    {liftSetting, senseGain, rippleCode} = '0;
    regVal = '{8'hC4, 8'hC2};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(railBCtrl, 8'hC4);
    chk(railCCtrl, 8'hC2);
    decRun(6);
    $display("test reset_defaults done");
    for (int i = 0; i < 8; i++)
    begin
      b = $random(seed);
      c = $random(seed);
      b[6:4] = i[2:0];
      c[6:4] = 3'h7 - i[2:0];
      {b[7], b[3], b[2], b[1], b[0]} = {i[0], i[1], i[2], ~i[0], i[1] ^ i[2]};
      {c[7], c[1], c[0]} = {~i[0], i[1], i[2]};
      regWr(8'h01, b, c, 2);
      chk(railBCtrl, regVal[0]);
      chk(railCCtrl, regVal[1]);
      decRun(10);
    end
    $display("test decode_codes done");
    for (int a = 1; a < 4; a++)
    begin
      regRd(a[7:0], rd);
      chk(rd, a == 3 ? 8'h00 : regVal[a - 1]);
    end
    regWr(8'h03, 8'h5A, 8'h00, 1);
    regRd(8'h03, rd);
    chk(rd, 8'h00);
    startC();
    sendByte({rail_comp_pkg::DEVICE_BUS_ADDR ^ 7'h01, 1'b0}, 1'b1);
    sendByte(8'h01, 1'b1);
    sendByte(8'h00, 1'b1);
    stopC();
    chk(railBCtrl, regVal[0]);
    $display("test readback done");
    @(posedge clk);
    ce <= 1'b0;
    rampDown <= 2'b11;
    repeat (3) @(posedge clk);
    #1 chk(fixedLiftOn, 2'b00);
    @(posedge clk);
    ce <= 1'b1;
    rampDown <= 2'b00;
    $display("test clock_enable done");
    @(posedge clk);
    reset_n <= 1'b0;
    #1;
    chk(railBCtrl, 8'hC4);
    chk(railCCtrl, 8'hC2);
    regVal = '{8'hC4, 8'hC2};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    regRd(8'h02, rd);
    chk(rd, 8'hC2);
    decRun(6);
    $display("test mid_reset done");
    wrap_up();
  end

  // a full run takes roughly 10k cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

endmodule // rail_bc_voltage_step_comp_regs_tb

`default_nettype wire

// File: rtl/rail_comp_decode.sv
// per-rail decode of one step-compensation control byte
// assumes ramp, exit and setting inputs come from logic on clk
`timescale 1ns/1ps
`default_nettype none

module rail_comp_decode #(
  parameter bit HAS_LIGHT_EXIT = 1'b1
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              ce,
  // control byte and regulator state
  input  wire logic [7:0]                        ctrl,
  input  wire logic                              rampDown,
  input  wire logic                              lightExit,
  input  wire logic [rail_comp_pkg::LIFT_W-1:0]  liftSetting,
  input  wire logic [rail_comp_pkg::GAIN_W-1:0]  senseGain,
  input  wire logic [rail_comp_pkg::RIPPLE_W-1:0] rippleCode,
  // steering outputs
  output logic                                   fixedLiftOn,
  output logic [rail_comp_pkg::PULL_W-1:0]       pullCurrent,
  output logic [rail_comp_pkg::GAIN_W:0]         senseGainEff,
  output logic [rail_comp_pkg::RIPPLE_W:0]       rippleFactor,
  output logic                                   targetRaise,
  output logic                                   filterClear
);

  localparam int PULL_W = rail_comp_pkg::PULL_W;

  logic [rail_comp_pkg::PULL_SCALE_W-1:0] pullScale;
  logic                                   lift_nxt;
  logic [rail_comp_pkg::PULL_W-1:0]       pull_nxt;
  logic [rail_comp_pkg::GAIN_W:0]         gain_nxt;
  logic [rail_comp_pkg::RIPPLE_W:0]       ripple_nxt;
  logic                                   raise_nxt;
  logic                                   clear_nxt;

  assign pullScale = ctrl[rail_comp_pkg::PULL_SCALE_MSB -:
                          rail_comp_pkg::PULL_SCALE_W];

  always_comb
  begin
    // active-low enable: lift only while ramping down
    lift_nxt = rampDown & ~ctrl[rail_comp_pkg::FIXED_LIFT_OFF_BIT];
    // quarter units of the lift current; code 0 gives zero
    pull_nxt = '0;
    if (rampDown)
    begin
      pull_nxt = PULL_W'(liftSetting) * PULL_W'(pullScale);
    end
    if (ctrl[rail_comp_pkg::GAIN_X2_BIT])
    begin
      gain_nxt = {senseGain, 1'b0};
    end
    else
    begin
      gain_nxt = {1'b0, senseGain};
    end
    if (ctrl[rail_comp_pkg::RIPPLE_X2_BIT])
    begin
      ripple_nxt = {rippleCode, 1'b0};
    end
    else
    begin
      ripple_nxt = {1'b0, rippleCode};
    end
    // one-cycle pulses on leaving the light-load state
    raise_nxt = HAS_LIGHT_EXIT & lightExit &
                ctrl[rail_comp_pkg::TARGET_RAISE_BIT];
    clear_nxt = HAS_LIGHT_EXIT & lightExit &
                ctrl[rail_comp_pkg::FILTER_CLEAR_BIT];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fixedLiftOn  <= 1'b0;
      pullCurrent  <= '0;
      senseGainEff <= '0;
      rippleFactor <= '0;
      targetRaise  <= 1'b0;
      filterClear  <= 1'b0;
    end
    else if (ce)
    begin
      fixedLiftOn  <= lift_nxt;
      pullCurrent  <= pull_nxt;
      senseGainEff <= gain_nxt;
      rippleFactor <= ripple_nxt;
      targetRaise  <= raise_nxt;
      filterClear  <= clear_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_fixed_lift: assert property (@(posedge clk) disable iff (!reset_n)
    ce && rampDown && !ctrl[7] |=> fixedLiftOn)
    else $error("fixed lift not applied on downward ramp");
  a_pull_zero: assert property (@(posedge clk) disable iff (!reset_n)
    ce && (ctrl[6:4] == 3'h0 || !rampDown) |=> pullCurrent == 7'h00)
    else $error("pull current not zero when disabled");
  a_pull_scale: assert property (@(posedge clk) disable iff (!reset_n)
    ce && rampDown |=>
      pullCurrent == 7'($past(liftSetting)) * 7'($past(ctrl[6:4])))
    else $error("pull current does not follow lift setting");
  a_exit_raise: assert property (@(posedge clk) disable iff (!reset_n)
    ce |=> targetRaise == (HAS_LIGHT_EXIT && $past(lightExit)
                           && $past(ctrl[3])))
    else $error("target raise wrong on light-load exit");
  a_exit_clear: assert property (@(posedge clk) disable iff (!reset_n)
    ce ##0 lightExit && ctrl[2] && HAS_LIGHT_EXIT |=> filterClear ##1
      (filterClear == ($past(ce) ? $past(lightExit) && $past(ctrl[2])
                                 : 1'b1)))
    else $error("filter clear wrong on light-load exit");
  a_gain_double: assert property (@(posedge clk) disable iff (!reset_n)
    ce && ctrl[1] |=> senseGainEff == {$past(senseGain), 1'b0})
    else $error("sense gain not doubled");
  a_ripple_double: assert property (@(posedge clk) disable iff (!reset_n)
    ce && ctrl[0] |=> rippleFactor == {$past(rippleCode), 1'b0})
    else $error("ripple factor not doubled");
  a_ripple_plain: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !ctrl[0] |=> rippleFactor == {1'b0, $past(rippleCode)})
    else $error("ripple factor not plain code");

endmodule // rail_comp_decode

`default_nettype wire

// File: rtl/rail_comp_pkg.sv
// constants for the rail B/C downward-ramp compensation register bank
// assumes a two-wire serial host and regulator logic on the same clock
package rail_comp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] RAIL_B_STEP_COMP_CTRL_ADDR = 8'h01;
  localparam logic [7:0] RAIL_C_STEP_COMP_CTRL_ADDR = 8'h02;
  localparam logic [7:0] RAIL_B_STEP_COMP_CTRL_RST  = 8'hC4;
  localparam logic [7:0] RAIL_C_STEP_COMP_CTRL_RST  = 8'hC2;
  localparam logic [7:0] UNMAPPED_READ_VALUE        = 8'h00;

  // bus address of this device; value is arbitrary
  localparam logic [6:0] DEVICE_BUS_ADDR = 7'h2A;

  ////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int FIXED_LIFT_OFF_BIT = 7;
  localparam int PULL_SCALE_MSB     = 6;
  localparam int PULL_SCALE_W       = 3;
  localparam int TARGET_RAISE_BIT   = 3;
  localparam int FILTER_CLEAR_BIT   = 2;
  localparam int GAIN_X2_BIT        = 1;
  localparam int RIPPLE_X2_BIT      = 0;

  // fixed lift applied on downward ramps, in mV
  localparam int FIXED_LIFT_MV = 15;

  ////////////////////////////////////////////////////////////////////////////
  // rails and widths
  localparam int RAIL_COUNT = 2;
  localparam int RAIL_B     = 0;
  localparam int RAIL_C     = 1;
  localparam int LIFT_W     = 4;
  localparam int GAIN_W     = 3;
  localparam int RIPPLE_W   = 3;
  localparam int PULL_W     = 7;

  localparam logic [3:0] BYTE_BITS = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave states, gray along the usual path
  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_DEVADDR = 4'h1,
    S_ADDRACK = 4'h3,
    S_PTR     = 4'h2,
    S_PTRACK  = 4'h6,
    S_WRITE   = 4'h7,
    S_WRACK   = 4'h5,
    S_READ    = 4'h4,
    S_RDACK   = 4'hC
  } bus_state_e;

endpackage

// File: rtl/rail_step_comp_regs.sv
// rail B/C step-compensation registers behind a two-wire serial slave
// assumes open-drain scl/sda pins resolved outside; one clock domain
`timescale 1ns/1ps
`default_nettype none

module rail_step_comp_regs (
  // clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    reset_n,
  input  wire logic                                    ce,
  // serial bus pins
  input  wire logic                                    sclIn,
  input  wire logic                                    sdaIn,
  output logic                                         sdaOut,
  output logic                                         sdaOe,
  // regulator state, index 0 rail B, 1 rail C
  input  wire logic [1:0]                              rampDown,
  input  wire logic                                    lightExit,
  input  wire logic [1:0][rail_comp_pkg::LIFT_W-1:0]   liftSetting,
  input  wire logic [1:0][rail_comp_pkg::GAIN_W-1:0]   senseGain,
  input  wire logic [1:0][rail_comp_pkg::RIPPLE_W-1:0] rippleCode,
  // register contents
  output logic [7:0]                                   railBCtrl,
  output logic [7:0]                                   railCCtrl,
  // steering outputs
  output logic [1:0]                                   fixedLiftOn,
  output logic [1:0][rail_comp_pkg::PULL_W-1:0]        pullCurrent,
  output logic [1:0][rail_comp_pkg::GAIN_W:0]          senseGainEff,
  output logic [1:0][rail_comp_pkg::RIPPLE_W:0]        rippleFactor,
  output logic [1:0]                                   targetRaise,
  output logic [1:0]                                   filterClear
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; third stage only for edge detection
  logic sclMeta_r, sclSync_r, sclDly_r;
  logic sdaMeta_r, sdaSync_r, sdaDly_r;
  logic sclRise, sclFall, busStart, busStop;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
      sclDly_r  <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
      sdaDly_r  <= 1'b1;
    end
    else if (ce)
    begin
      sclMeta_r <= sclIn;
      sclSync_r <= sclMeta_r;
      sclDly_r  <= sclSync_r;
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
      sdaDly_r  <= sdaSync_r;
    end
  end

  assign sclRise  = sclSync_r & ~sclDly_r;
  assign sclFall  = ~sclSync_r & sclDly_r;
  assign busStart = sclSync_r & sclDly_r & sdaDly_r & ~sdaSync_r;
  assign busStop  = sclSync_r & sclDly_r & ~sdaDly_r & sdaSync_r;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave: pointer byte then data, pointer auto-increments
  rail_comp_pkg::bus_state_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic       read_r, read_nxt;
  logic       sdaOe_r, sdaOe_nxt;
  logic       wrEn;
  logic [7:0] nextByte;
  logic [7:0] ctrlB_r, ctrlB_nxt;
  logic [7:0] ctrlC_r, ctrlC_nxt;

  // unmapped offsets read as a fixed value and ignore writes
  function automatic logic [7:0] readByte(input logic [7:0] addr,
                                          input logic [7:0] b,
                                          input logic [7:0] c);
    logic [7:0] v;
    v = rail_comp_pkg::UNMAPPED_READ_VALUE;
    if (addr == rail_comp_pkg::RAIL_B_STEP_COMP_CTRL_ADDR)
    begin
      v = b;
    end
    else if (addr == rail_comp_pkg::RAIL_C_STEP_COMP_CTRL_ADDR)
    begin
      v = c;
    end
    return v;
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt   = ptr_r;
    read_nxt  = read_r;
    sdaOe_nxt = sdaOe_r;
    wrEn      = 1'b0;
    nextByte  = readByte(ptr_r + 8'h01, ctrlB_r, ctrlC_r);
    if (busStart)
    begin
      state_nxt = rail_comp_pkg::S_DEVADDR;
      cnt_nxt   = 4'h0;
      sdaOe_nxt = 1'b0;
    end
    else if (busStop)
    begin
      state_nxt = rail_comp_pkg::S_IDLE;
      sdaOe_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        rail_comp_pkg::S_DEVADDR,
        rail_comp_pkg::S_PTR,
        rail_comp_pkg::S_WRITE:
        begin
          if (sclRise)
          begin
            shift_nxt = {shift_r[6:0], sdaSync_r};
            cnt_nxt   = cnt_r + 4'h1;
          end
          else if (sclFall && cnt_r == rail_comp_pkg::BYTE_BITS)
          begin
            sdaOe_nxt = 1'b1;
            if (state_r == rail_comp_pkg::S_DEVADDR)
            begin
              read_nxt  = shift_r[0];
              state_nxt = rail_comp_pkg::S_ADDRACK;
              if (shift_r[7:1] != rail_comp_pkg::DEVICE_BUS_ADDR)
              begin
                // not ours: stay off the bus until the next start
                state_nxt = rail_comp_pkg::S_IDLE;
                sdaOe_nxt = 1'b0;
              end
            end
            else if (state_r == rail_comp_pkg::S_PTR)
            begin
              ptr_nxt   = shift_r;
              state_nxt = rail_comp_pkg::S_PTRACK;
            end
            else
            begin
              wrEn      = 1'b1;
              state_nxt = rail_comp_pkg::S_WRACK;
            end
          end
        end
        rail_comp_pkg::S_ADDRACK:
        begin
          if (sclFall)
          begin
            cnt_nxt = 4'h0;
            if (read_r)
            begin
              shift_nxt = readByte(ptr_r, ctrlB_r, ctrlC_r);
              sdaOe_nxt = ~shift_nxt[7];
              state_nxt = rail_comp_pkg::S_READ;
            end
            else
            begin
              sdaOe_nxt = 1'b0;
              state_nxt = rail_comp_pkg::S_PTR;
            end
          end
        end
        rail_comp_pkg::S_PTRACK,
        rail_comp_pkg::S_WRACK:
        begin
          if (sclFall)
          begin
            if (state_r == rail_comp_pkg::S_WRACK)
            begin
              ptr_nxt = ptr_r + 8'h01;
            end
            cnt_nxt   = 4'h0;
            sdaOe_nxt = 1'b0;
            state_nxt = rail_comp_pkg::S_WRITE;
          end
        end
        rail_comp_pkg::S_READ:
        begin
          if (sclRise)
          begin
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (sclFall && cnt_r == rail_comp_pkg::BYTE_BITS)
          begin
            sdaOe_nxt = 1'b0;
            state_nxt = rail_comp_pkg::S_RDACK;
          end
          else if (sclFall)
          begin
            shift_nxt = {shift_r[6:0], 1'b0};
            sdaOe_nxt = ~shift_r[6];
          end
        end
        rail_comp_pkg::S_RDACK:
        begin
          if (sclRise && sdaSync_r)
          begin
            // host refused more data
            state_nxt = rail_comp_pkg::S_IDLE;
          end
          else if (sclFall)
          begin
            ptr_nxt   = ptr_r + 8'h01;
            shift_nxt = nextByte;
            sdaOe_nxt = ~nextByte[7];
            cnt_nxt   = 4'h0;
            state_nxt = rail_comp_pkg::S_READ;
          end
        end
        default:
        begin
          state_nxt = rail_comp_pkg::S_IDLE;
          sdaOe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= rail_comp_pkg::S_IDLE;
      cnt_r   <= 4'h0;
      shift_r <= 8'h00;
      ptr_r   <= 8'h00;
      read_r  <= 1'b0;
      sdaOe_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r   <= ptr_nxt;
      read_r  <= read_nxt;
      sdaOe_r <= sdaOe_nxt;
    end
  end

  // open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_r;

  ////////////////////////////////////////////////////////////////////////////
  // register bank; reserved bits of rail C are plain storage
  always_comb
  begin
    ctrlB_nxt = ctrlB_r;
    ctrlC_nxt = ctrlC_r;
    if (wrEn && ptr_r == rail_comp_pkg::RAIL_B_STEP_COMP_CTRL_ADDR)
    begin
      ctrlB_nxt = shift_r;
    end
    if (wrEn && ptr_r == rail_comp_pkg::RAIL_C_STEP_COMP_CTRL_ADDR)
    begin
      ctrlC_nxt = shift_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrlB_r <= rail_comp_pkg::RAIL_B_STEP_COMP_CTRL_RST;
      ctrlC_r <= rail_comp_pkg::RAIL_C_STEP_COMP_CTRL_RST;
    end
    else if (ce)
    begin
      ctrlB_r <= ctrlB_nxt;
      ctrlC_r <= ctrlC_nxt;
    end
  end

  assign railBCtrl = ctrlB_r;
  assign railCCtrl = ctrlC_r;

  ////////////////////////////////////////////////////////////////////////////
  // per-rail decode; light-load exit bits exist on rail B only
  genvar r;
  for (r = 0; r < rail_comp_pkg::RAIL_COUNT; r++)
  begin : g_rail
    rail_comp_decode #(
      .HAS_LIGHT_EXIT (r == rail_comp_pkg::RAIL_B)
    ) u_decode (
      .clk          (clk),
      .reset_n      (reset_n),
      .ce           (ce),
      .ctrl         ((r == rail_comp_pkg::RAIL_B) ? ctrlB_r : ctrlC_r),
      .rampDown     (rampDown[r]),
      .lightExit    (lightExit),
      .liftSetting  (liftSetting[r]),
      .senseGain    (senseGain[r]),
      .rippleCode   (rippleCode[r]),
      .fixedLiftOn  (fixedLiftOn[r]),
      .pullCurrent  (pullCurrent[r]),
      .senseGainEff (senseGainEff[r]),
      .rippleFactor (rippleFactor[r]),
      .targetRaise  (targetRaise[r]),
      .filterClear  (filterClear[r])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ctrl_write: assert property (@(posedge clk) disable iff (!reset_n)
    ce && wrEn && ptr_r == 8'h01 |=> railBCtrl == $past(shift_r))
    else $error("rail B register did not take written byte");
  a_ctrl_keep: assert property (@(posedge clk) disable iff (!reset_n)
    !ce || !wrEn |=> $stable(railBCtrl) && $stable(railCCtrl))
    else $error("control register changed without a write");

endmodule // rail_step_comp_regs

`default_nettype wire
